// file: hw/timer_module_common_core.sv
`timescale 1ns/1ps
`include "tm_defs.svh"

// One timer: counter, two comparators, pins and byte access
module timer_channel #(
  parameter int CNT_W = `STD_CNT_W,
  parameter int P_SHIFT = `STD_P_SHIFT,
  parameter bit CAP_ALT = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input tm_pkg::chan_req_t req,
  input wire logic ext_clk,
  input wire logic cap_pin,
  input wire logic fh_tick,
  input wire logic fsub_tick,
  output logic [7:0] rdata,
  output logic out_pin,
  output logic out_oe,
  output logic irq_a,
  output logic irq_p
);
  import tm_pkg::*;

  // Masks for the counter width and the ignored low bits of P
  localparam logic [15:0] CNT_MASK = 16'((32'h1 << CNT_W) - 32'h1);
  localparam logic [15:0] LO_MASK = 16'((32'h1 << P_SHIFT) - 32'h1);
  localparam logic [15:0] P_MASK = CNT_MASK >> P_SHIFT;

  chan_state_t st_reg; // Registered state
  chan_state_t st_next; // Next state
  logic tick; // Selected counter clock event
  logic ck_rise; // Clock pin rising edge
  logic ck_fall; // Clock pin falling edge
  logic src_now; // Capture source level
  logic src_d; // Capture source delayed
  logic cap_evt; // Capture edge seen
  logic pulse_mode; // Single pulse selected
  logic run; // Counter may advance
  logic match_a; // Comparator A hit
  logic match_p; // Comparator P hit
  logic period_m; // PWM period end
  logic duty_m; // PWM duty end
  logic clr; // Clear on this match
  logic act; // Active output level

  // Next state of the timer
  always_comb begin
    st_next = st_reg;
    st_next.irq_a = 1'b0;
    st_next.irq_p = 1'b0;

    st_next.ck_s1 = ext_clk;
    st_next.cap_s1 = cap_pin;
    st_next.ck_s2 = st_reg.ck_s1 & st_reg.pc.clk_in_en;
    st_next.cap_s2 = st_reg.cap_s1 & st_reg.pc.cap_in_en;
    st_next.ck_d = st_reg.ck_s2;
    st_next.cap_d = st_reg.cap_s2;

    ck_rise = st_reg.ck_s2 & ~st_reg.ck_d;
    ck_fall = ~st_reg.ck_s2 & st_reg.ck_d;

    if (CAP_ALT && st_reg.pc.cap_from_clk) begin
      src_now = st_reg.ck_s2;
      src_d = st_reg.ck_d;
    end else begin
      src_now = st_reg.cap_s2;
      src_d = st_reg.cap_d;
    end

    case (st_reg.c1.pin_func)
      `IO_RISE: cap_evt = src_now & ~src_d;
      `IO_FALL: cap_evt = ~src_now & src_d;
      `IO_BOTH: cap_evt = src_now ^ src_d;
      default: cap_evt = 1'b0;
    endcase

    // Free running prescalers
    st_next.pre_sys = st_reg.pre_sys + 2'h1;
    if (fh_tick) begin
      st_next.pre_fh = st_reg.pre_fh + 6'h01;
    end

    unique case (st_reg.c0.clk_sel)
      `CK_SYS4: tick = (st_reg.pre_sys == `SYS4_LAST);
      `CK_SYS: tick = 1'b1;
      `CK_FH16: tick = fh_tick & ((st_reg.pre_fh & `FH16_MASK) == `FH16_MASK);
      `CK_FH64: tick = fh_tick & ((st_reg.pre_fh & `FH64_MASK) == `FH64_MASK);
      `CK_SUB_A: tick = fsub_tick;
      `CK_SUB_B: tick = fsub_tick;
      `CK_EXT_RISE: tick = ck_rise;
      `CK_EXT_FALL: tick = ck_fall;
    endcase

    // Mode decode and run condition
    pulse_mode = (st_reg.c1.mode == `MODE_PWM) && (st_reg.c1.pin_func == `IO_PULSE);
    run = st_reg.c0.on & ~st_reg.c0.pause & (~pulse_mode | st_reg.pulse);
    act = st_reg.c1.init_level;

    match_a = run & tick & (st_reg.cnt == (st_reg.cmp_a & CNT_MASK));
    match_p = run & tick & (((st_reg.cnt >> P_SHIFT) & P_MASK) == (st_reg.cmp_p & P_MASK))
      & ((st_reg.cnt & LO_MASK) == `ZERO_WORD);

    period_m = st_reg.c1.dpx ? match_a : match_p;
    duty_m = st_reg.c1.dpx ? match_p : match_a;

    // Clearing comparator per mode
    if (st_reg.c1.mode == `MODE_PWM) begin
      clr = pulse_mode ? match_a : period_m;
    end else begin
      clr = st_reg.c1.cclr ? match_a : match_p;
    end

    if (run && tick) begin
      if (clr) begin
        st_next.cnt = `ZERO_WORD;
      end else begin
        st_next.cnt = (st_reg.cnt + 16'h0001) & CNT_MASK;
      end
    end

    st_next.irq_a = match_a;
    st_next.irq_p = match_p;

    unique case (st_reg.c1.mode)
      `MODE_CMP: begin
        if (match_a) begin
          unique case (st_reg.c1.pin_func)
            `IO_NONE: st_next.out = st_reg.out;
            `IO_LOW: st_next.out = 1'b0;
            `IO_HIGH: st_next.out = 1'b1;
            `IO_TOGGLE: st_next.out = ~st_reg.out;
          endcase
        end
      end
      `MODE_CAP: begin
        // Capture latches count into A
        st_next.irq_a = cap_evt & st_reg.c0.on;
        if (cap_evt && st_reg.c0.on) begin
          st_next.cmp_a = st_reg.cnt;
        end
      end
      `MODE_PWM: begin
        unique case (st_reg.c1.pin_func)
          `IO_INACT: st_next.out = ~act;
          `IO_ACT: st_next.out = act;
          `IO_PWM: begin
            if (period_m) begin
              st_next.out = act;
            end else if (duty_m) begin
              st_next.out = ~act;
            end
          end
          `IO_PULSE: begin
            if (ck_rise && st_reg.c0.on && !st_reg.pulse) begin
              st_next.pulse = 1'b1;
              st_next.cnt = `ZERO_WORD;
              st_next.out = act;
            end else if (st_reg.pulse && match_a) begin
              st_next.pulse = 1'b0;
              st_next.out = ~act;
            end
          end
        endcase
      end
      `MODE_TMR: begin
        // Output holds its level
        st_next.out = st_reg.out;
      end
    endcase

    // Switch on clears counter and sets initial output
    st_next.on_d = st_reg.c0.on;
    if (st_reg.c0.on && !st_reg.on_d) begin
      st_next.cnt = `ZERO_WORD;
      st_next.pulse = 1'b0;
      if (st_reg.c1.mode == `MODE_CMP) begin
        st_next.out = st_reg.c1.init_level;
      end else begin
        st_next.out = ~st_reg.c1.init_level;
      end
    end

    // Register writes
    if (req.wr) begin
      case (req.ofs)
        `OFS_CTRL0: begin
          st_next.c0 = req.wdata;
          st_next.c0.rsv = 3'h0;
        end
        `OFS_CTRL1: st_next.c1 = req.wdata;
        `OFS_PINCFG: begin
          st_next.pc = req.wdata;
          st_next.pc.rsv = 4'h0;
          st_next.pc.cap_from_clk = req.wdata[3] & CAP_ALT;
        end
        `OFS_CMPA_L: st_next.byte_buf = req.wdata;
        `OFS_CMPP_L: st_next.byte_buf = req.wdata;
        `OFS_CMPA_H: st_next.cmp_a = {req.wdata, st_reg.byte_buf} & CNT_MASK;
        `OFS_CMPP_H: st_next.cmp_p = {req.wdata, st_reg.byte_buf} & CNT_MASK;
        default: st_next.cmp_a = st_next.cmp_a;
      endcase
    end

    if (req.rd) begin
      case (req.ofs)
        `OFS_CNT_H: st_next.byte_buf = st_reg.cnt[7:0];
        `OFS_CMPA_H: st_next.byte_buf = st_reg.cmp_a[7:0];
        `OFS_CMPP_H: st_next.byte_buf = st_reg.cmp_p[7:0];
        default: st_next.byte_buf = st_next.byte_buf;
      endcase
    end
  end

  // read mux, low bytes via buffer
  always_comb begin
    case (req.ofs)
      `OFS_CTRL0: rdata = st_reg.c0;
      `OFS_CTRL1: rdata = st_reg.c1;
      `OFS_PINCFG: rdata = st_reg.pc;
      `OFS_CNT_L: rdata = st_reg.byte_buf;
      `OFS_CMPA_L: rdata = st_reg.byte_buf;
      `OFS_CMPP_L: rdata = st_reg.byte_buf;
      `OFS_CNT_H: rdata = st_reg.cnt[15:8];
      `OFS_CMPA_H: rdata = st_reg.cmp_a[15:8];
      `OFS_CMPP_H: rdata = st_reg.cmp_p[15:8];
      default: rdata = `ZERO_BYTE;
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_pin = st_reg.pc.out_en & (st_reg.out ^ st_reg.c1.pol);
  assign out_oe = st_reg.pc.out_en;
  assign irq_a = st_reg.irq_a;
  assign irq_p = st_reg.irq_p;
endmodule

// AHB-Lite slave over one standard and several periodic timers
module timer_module_common_core #(
  parameter int PER_N = `PER_COUNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fh_tick,
  input wire logic fsub_tick,
  input wire logic std_ext_clock_pin,
  input wire logic std_capture_pin,
  output logic std_output_pin,
  output logic std_output_inverted,
  output logic std_output_oe,
  output logic std_irq_a,
  output logic std_irq_p,
  input wire logic [PER_N-1:0] per_ext_clock_pin,
  input wire logic [PER_N-1:0] per_capture_pin,
  output logic [PER_N-1:0] per_output_pin,
  output logic [PER_N-1:0] per_output_oe,
  output logic per0_output_inverted,
  output logic [PER_N-1:0] per_irq_a,
  output logic [PER_N-1:0] per_irq_p
);
  import tm_pkg::*;

  localparam int NCH = PER_N + 1; // Standard timer is window zero

  bus_state_t bs_reg; // Registered bus state
  bus_state_t bs_next; // Next bus state
  logic accept; // Address phase taken
  logic [1:0] sel; // Selected timer window
  logic [7:0] ch_rdata [NCH]; // Read data per timer
  logic [NCH-1:0] ch_out; // Output pin per timer
  logic [NCH-1:0] ch_oe; // Output enable per timer
  logic [NCH-1:0] ch_ia; // Comparator A event per timer
  logic [NCH-1:0] ch_ip; // Comparator P event per timer
  chan_req_t req [NCH]; // Access per timer

  // Bus phase sequencing; reads take one wait state
  always_comb begin
    bs_next = bs_reg;
    accept = hsel & hready & htrans[1];
    sel = bs_reg.addr[`CH_HI:`CH_LO];
    unique case (bs_reg.ph)
      PH_IDLE, PH_WRITE: begin
        if (accept) begin
          bs_next.ph = hwrite ? PH_WRITE : PH_READ;
          bs_next.addr = haddr[7:0];
          bs_next.hit = (haddr[31:`PAGE_LO] == 24'h0)
            && (int'(haddr[`CH_HI:`CH_LO]) < NCH);
        end else begin
          bs_next.ph = PH_IDLE;
        end
      end
      PH_READ: begin
        // Unmapped reads return zero
        bs_next.rdata = bs_reg.hit ? {24'h0, ch_rdata[sel]} : 32'h0;
        bs_next.ph = PH_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bs_reg <= '0;
    end else begin
      bs_reg <= bs_next;
    end
  end

  // Bus answers
  assign hreadyout = (bs_reg.ph != PH_READ);
  assign hresp = 1'b0;
  assign hrdata = bs_reg.rdata;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Access steering to this timer
    always_comb begin
      req[i].wr = (bs_reg.ph == PH_WRITE) && bs_reg.hit && (int'(sel) == i);
      req[i].rd = (bs_reg.ph == PH_READ) && bs_reg.hit && (int'(sel) == i);
      req[i].ofs = bs_reg.addr[`OFS_HI:0];
      req[i].wdata = hwdata[7:0];
    end
    if (i == 0) begin : g_std
      timer_channel #(
        .CNT_W(`STD_CNT_W),
        .P_SHIFT(`STD_P_SHIFT),
        .CAP_ALT(1'b0)
      ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(req[i]),
        .ext_clk(std_ext_clock_pin),
        .cap_pin(std_capture_pin),
        .fh_tick(fh_tick),
        .fsub_tick(fsub_tick),
        .rdata(ch_rdata[i]),
        .out_pin(ch_out[i]),
        .out_oe(ch_oe[i]),
        .irq_a(ch_ia[i]),
        .irq_p(ch_ip[i])
      );
    end else begin : g_per
      timer_channel #(
        .CNT_W(`PER_CNT_W),
        .P_SHIFT(`PER_P_SHIFT),
        .CAP_ALT(1'b1)
      ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(req[i]),
        .ext_clk(per_ext_clock_pin[i-1]),
        .cap_pin(per_capture_pin[i-1]),
        .fh_tick(fh_tick),
        .fsub_tick(fsub_tick),
        .rdata(ch_rdata[i]),
        .out_pin(ch_out[i]),
        .out_oe(ch_oe[i]),
        .irq_a(ch_ia[i]),
        .irq_p(ch_ip[i])
      );
    end
  end

  // Standard timer pins
  assign std_output_pin = ch_out[0];
  assign std_output_oe = ch_oe[0];
  assign std_output_inverted = ch_oe[0] & ~ch_out[0];
  assign std_irq_a = ch_ia[0];
  assign std_irq_p = ch_ip[0];

  // Periodic timer pins
  assign per_output_pin = ch_out[NCH-1:1];
  assign per_output_oe = ch_oe[NCH-1:1];
  assign per0_output_inverted = ch_oe[1] & ~ch_out[1];
  assign per_irq_a = ch_ia[NCH-1:1];
  assign per_irq_p = ch_ip[NCH-1:1];
endmodule

// file: hw/tm_defs.svh
`ifndef TM_DEFS_SVH
`define TM_DEFS_SVH

// Register byte offsets inside one timer window
`define OFS_CTRL0 6'h00
`define OFS_CTRL1 6'h04
`define OFS_CNT_L 6'h08
`define OFS_CNT_H 6'h0c
`define OFS_CMPA_L 6'h10
`define OFS_CMPA_H 6'h14
`define OFS_CMPP_L 6'h18
`define OFS_CMPP_H 6'h1c
`define OFS_PINCFG 6'h20

// Timer window select in the byte address
`define CH_HI 7
`define CH_LO 6
`define OFS_HI 5
`define PAGE_LO 8

// Clock select codes
`define CK_SYS4 3'h0
`define CK_SYS 3'h1
`define CK_FH16 3'h2
`define CK_FH64 3'h3
`define CK_SUB_A 3'h4
`define CK_SUB_B 3'h5
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7

// Operating modes
`define MODE_CMP 2'h0
`define MODE_CAP 2'h1
`define MODE_PWM 2'h2
`define MODE_TMR 2'h3

// Pin function codes per mode
`define IO_NONE 2'h0
`define IO_LOW 2'h1
`define IO_HIGH 2'h2
`define IO_TOGGLE 2'h3
`define IO_INACT 2'h0
`define IO_ACT 2'h1
`define IO_PWM 2'h2
`define IO_PULSE 2'h3
`define IO_RISE 2'h0
`define IO_FALL 2'h1
`define IO_BOTH 2'h2
`define IO_OFF 2'h3

// Prescaler terminal values
`define SYS4_LAST 2'h3
`define FH16_MASK 6'h0f
`define FH64_MASK 6'h3f

// Timer geometry
`define STD_CNT_W 16
`define PER_CNT_W 10
`define STD_P_SHIFT 8
`define PER_P_SHIFT 0
`define PER_COUNT 3
`define ZERO_WORD 16'h0000
`define ZERO_BYTE 8'h00

`endif

// file: hw/tm_pkg.sv
package tm_pkg;

  // First control register layout
  typedef struct packed {
    logic pause;
    logic [2:0] clk_sel;
    logic on;
    logic [2:0] rsv;
  } ctrl0_t;

  // Second control register layout
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pin_func;
    logic init_level;
    logic pol;
    logic dpx;
    logic cclr;
  } ctrl1_t;

  // Pin routing register layout
  typedef struct packed {
    logic [3:0] rsv;
    logic cap_from_clk;
    logic cap_in_en;
    logic clk_in_en;
    logic out_en;
  } pincfg_t;

  // Register access toward one timer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] ofs;
    logic [7:0] wdata;
  } chan_req_t;

  // Whole state of one timer
  typedef struct packed {
    ctrl0_t c0;
    ctrl1_t c1;
    pincfg_t pc;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [15:0] cmp_p;
    logic [7:0] byte_buf;
    logic [1:0] pre_sys;
    logic [5:0] pre_fh;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic cap_s1;
    logic cap_s2;
    logic cap_d;
    logic out;
    logic on_d;
    logic pulse;
    logic irq_a;
    logic irq_p;
  } chan_state_t;

  // Bus transfer phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } bus_phase_t;

  // Whole state of the bus slave
  typedef struct packed {
    bus_phase_t ph;
    logic hit;
    logic [7:0] addr;
    logic [31:0] rdata;
  } bus_state_t;

endpackage

// file: test/tm_asserts.sv
`timescale 1ns/1ps

// Watches bus handshake and output pin relations
module tm_asserts #(
  parameter int PER_N = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic std_output_pin,
  input wire logic std_output_inverted,
  input wire logic std_output_oe,
  input wire logic std_irq_a,
  input wire logic [PER_N-1:0] per_output_pin,
  input wire logic [PER_N-1:0] per_output_oe,
  input wire logic per0_output_inverted
);
  // Transfer accepted at this edge
  logic take;
  assign take = hsel & hready & htrans[1];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_std_inverse: assert property (std_output_inverted == (std_output_oe & ~std_output_pin))
    else $error("standard inverted pin wrong");
  a_per_inverse: assert property (per0_output_inverted == (per_output_oe[0] & ~per_output_pin[0]))
    else $error("periodic inverted pin wrong");
  a_std_gated: assert property (!std_output_oe |-> !std_output_pin)
    else $error("standard pin driven while deselected");
  a_per_gated: assert property (!per_output_oe[0] |-> !per_output_pin[0])
    else $error("periodic pin driven while deselected");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_ready: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved between reads");

  // Main scenarios reached
  c_read: cover property (take && !hwrite);
  c_out_rise: cover property ($rose(std_output_pin));
  c_irq: cover property (std_irq_a);
endmodule

bind timer_module_common_core tm_asserts #(.PER_N(PER_N)) u_tm_asserts (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .std_output_pin(std_output_pin),
  .std_output_inverted(std_output_inverted),
  .std_output_oe(std_output_oe),
  .std_irq_a(std_irq_a),
  .per_output_pin(per_output_pin),
  .per_output_oe(per_output_oe),
  .per0_output_inverted(per0_output_inverted)
);

// file: test/tm_pins_model.sv
`timescale 1ns/1ps

// External clock and capture sources of the standard timer
module tm_pins_model (
  input wire logic hclk,
  output logic ext_clk,
  output logic cap_pin
);
  // Both pins rest low between bursts
  initial begin
    ext_clk = 1'b0;
    cap_pin = 1'b0;
  end

  // n pulses, w cycles per level
  task automatic clk_burst(input int n, input int w);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (w) @(posedge hclk);
      ext_clk <= 1'b0;
      repeat (w) @(posedge hclk);
    end
  endtask

  // one rising then one falling edge
  task automatic cap_cycle();
    cap_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    cap_pin <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// file: test/timer_module_common_core_test.sv
`timescale 1ns/1ps
`include "tm_defs.svh"

// Register, compare, event and capture tests
module timer_module_common_core_test;
  import tm_pkg::*;
  localparam int PER_N = 3;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic fh_tick = 1'b0;
  logic fsub_tick = 1'b0;
  logic [2:0] tk = 3'h0;
  logic std_ext_clock_pin;
  logic std_capture_pin;
  logic std_output_pin;
  logic std_output_inverted;
  logic std_output_oe;
  logic std_irq_a;
  logic std_irq_p;
  logic [PER_N-1:0] per_ext_clock_pin = '0;
  logic [PER_N-1:0] per_capture_pin = '0;
  logic [PER_N-1:0] per_output_pin;
  logic [PER_N-1:0] per_output_oe;
  logic per0_output_inverted;
  logic [PER_N-1:0] per_irq_a;
  logic [PER_N-1:0] per_irq_p;
  logic [31:0] rd_q;
  logic prev = 1'b0;
  int err_total = 0;
  int checked = 0;
  int na = 0;
  int pa = 0;
  int pp = 0;
  int nt = 0;
  int sp = 0;
  int hp = 0;
  // Compare setup: std toggle on A, clear on A; periodic high on A, clear on P
  logic [15:0] cmp_cfg [12] = '{16'h1009, 16'h1400, 16'h0431, 16'h2001, 16'h5002,
    16'h5400, 16'h5804, 16'h5c00, 16'h4420, 16'h6001, 16'h4018, 16'h0018};

  // System clock
  always #25 hclk = ~hclk;

  // Slow internal ticks
  always @(posedge hclk) begin
    tk <= tk + 3'h1;
    fh_tick <= ~fh_tick;
    fsub_tick <= (tk == 3'h7);
  end

  // Counts interrupt pulses and output toggles
  always @(posedge hclk) begin
    prev <= std_output_pin;
    if (std_irq_a === 1'b1) na <= na + 1;
    if (per_irq_a[0] === 1'b1) pa <= pa + 1;
    if (per_irq_p[0] === 1'b1) pp <= pp + 1;
    if (std_output_pin !== prev) nt <= nt + 1;
    if (std_irq_p === 1'b1) sp <= sp + 1;
    if (per_output_pin[0] === 1'b1) hp <= hp + 1;
  end

  timer_module_common_core #(.PER_N(PER_N)) u_timer_module_common_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fh_tick(fh_tick),
    .fsub_tick(fsub_tick), .std_ext_clock_pin(std_ext_clock_pin),
    .std_capture_pin(std_capture_pin), .std_output_pin(std_output_pin),
    .std_output_inverted(std_output_inverted), .std_output_oe(std_output_oe),
    .std_irq_a(std_irq_a), .std_irq_p(std_irq_p), .per_ext_clock_pin(per_ext_clock_pin),
    .per_capture_pin(per_capture_pin), .per_output_pin(per_output_pin),
    .per_output_oe(per_output_oe), .per0_output_inverted(per0_output_inverted),
    .per_irq_a(per_irq_a), .per_irq_p(per_irq_p)
  );

  tm_pins_model u_tm_pins_model (
    .hclk(hclk),
    .ext_clk(std_ext_clock_pin),
    .cap_pin(std_capture_pin)
  );

  // Verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compares one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for an edge with ready high, bounded
  task automatic wait_rdy();
    int n = 0;
    logic r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      rd_q = hrdata;
      @(posedge hclk);
      n++;
      if (n > 50) begin
        err_total++;
        complete_run();
      end
    end
  endtask

  // Single word write
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask

  // Single word read
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = rd_q;
  endtask

  // high byte first, then buffered low byte
  task automatic rd16(input logic [7:0] hi, output logic [31:0] v);
    logic [31:0] h;
    logic [31:0] l;
    bus_rd(hi, h);
    bus_rd(hi - 8'h04, l);
    v = {16'h0, h[7:0], l[7:0]};
  endtask

  // Main sequence
  initial begin
    logic [31:0] v;
    int n0;
    int n1;
    int n2;
    int n3;
    int n4;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({hreadyout, std_output_pin, std_irq_a}, 32'h4);
    bus_rd(`OFS_CTRL1, v);
    chk(v, 32'h0);
    bus_rd(8'h24, v);
    chk(v, 32'h0);
    // Byte pair through the buffer
    bus_wr(`OFS_CMPA_L, 8'h34);
    bus_wr(`OFS_CMPA_H, 8'h12);
    rd16(`OFS_CMPA_H, v);
    chk(v, 32'h1234);
    bus_wr(`OFS_CMPA_L, 8'h56);
    rd16(`OFS_CMPA_H, v);
    chk(v, 32'h1234);
    // Compare matches on both timers
    for (int i = 0; i < 12; i++) bus_wr(cmp_cfg[i][15:8], cmp_cfg[i][7:0]);
    repeat (20) @(posedge hclk);
    n0 = na;
    n1 = pa;
    n2 = pp;
    n3 = nt;
    n4 = sp;
    repeat (100) @(posedge hclk);
    chk(na - n0, 10);
    chk(nt - n3, 10);
    chk(sp - n4, 10);
    chk(pa - n1, 20);
    chk(pp - n2, 20);
    chk(per_output_pin[0], 1);
    // Periodic PWM: period P of five counts, high for three
    bus_wr(8'h40, 8'h00);
    bus_wr(8'h44, 8'ha8);
    bus_wr(8'h40, 8'h18);
    repeat (20) @(posedge hclk);
    n0 = hp;
    repeat (100) @(posedge hclk);
    chk(hp - n0, 60);
    // Periodic capture taken from its clock pin, rising only
    bus_wr(8'h40, 8'h00);
    bus_wr(8'h44, 8'h40);
    bus_wr(8'h60, 8'h0a);
    bus_wr(8'h40, 8'h18);
    n0 = pa;
    per_ext_clock_pin[0] <= 1'b1;
    repeat (6) @(posedge hclk);
    per_ext_clock_pin[0] <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(pa - n0, 1);
    // Event counting on rising then falling edges
    bus_wr(`OFS_CTRL0, 8'h00);
    bus_wr(`OFS_CTRL1, 8'hc1);
    bus_wr(`OFS_PINCFG, 8'h02);
    bus_wr(`OFS_CTRL0, 8'h68);
    u_tm_pins_model.clk_burst(5, 4);
    rd16(`OFS_CNT_H, v);
    chk(v, 32'h5);
    chk(std_output_pin, 0);
    bus_wr(`OFS_CTRL0, 8'h00);
    bus_wr(`OFS_CTRL0, 8'h78);
    u_tm_pins_model.clk_burst(3, 2);
    rd16(`OFS_CNT_H, v);
    chk(v, 32'h3);
    bus_wr(`OFS_PINCFG, 8'h00);
    u_tm_pins_model.clk_burst(2, 4);
    rd16(`OFS_CNT_H, v);
    chk(v, 32'h3);
    // Capture edge codes
    for (int k = 0; k < 4; k++) begin
      bus_wr(`OFS_CTRL0, 8'h00);
      bus_wr(`OFS_CTRL1, {2'b01, k[1:0], 4'h0});
      bus_wr(`OFS_PINCFG, 8'h04);
      bus_wr(`OFS_CTRL0, 8'h18);
      n0 = na;
      u_tm_pins_model.cap_cycle();
      repeat (6) @(posedge hclk);
      chk(na - n0, (k == 3) ? 0 : ((k == 2) ? 2 : 1));
    end
    // Single pulse started by the clock pin
    bus_wr(`OFS_CTRL0, 8'h00);
    bus_wr(`OFS_CTRL1, 8'hb9);
    // Pulse lasts eleven counts; capture left comparator A at zero
    bus_wr(`OFS_CMPA_L, 8'h0a);
    bus_wr(`OFS_CMPA_H, 8'h00);
    bus_wr(`OFS_PINCFG, 8'h03);
    bus_wr(`OFS_CTRL0, 8'h18);
    repeat (4) @(posedge hclk);
    n0 = nt;
    u_tm_pins_model.clk_burst(1, 4);
    chk(std_output_pin, 1);
    repeat (20) @(posedge hclk);
    chk(nt - n0, 2);
    complete_run();
  end
endmodule
